//--- logic/fvb_defines.svh
// Register offsets, field positions and reset values for the field 1 blanking block
`ifndef FVB_DEFINES_SVH
`define FVB_DEFINES_SVH

`define FVB_ADDR_W          6
`define FVB_OFF_START       6'h00
`define FVB_OFF_END         6'h04
`define FVB_OFF_FRAME       6'h08
`define FVB_OFF_CTRL        6'h0c
`define FVB_OFF_STAT        6'h10

`define FVB_LINE_HI         27
`define FVB_LINE_LO         16
`define FVB_PIX_HI          11
`define FVB_PIX_LO          0
`define FVB_COORD_MASK      32'h0fff_0fff

`define FVB_CTRL_RUN        0
`define FVB_CTRL_VBIT       1
`define FVB_CTRL_MODE_LO    4
`define FVB_CTRL_MODE_HI    5
`define FVB_CTRL_MASK       32'h0000_0033
`define FVB_STAT_BLANK      31

`define FVB_RST_REG         32'h0000_0000
`define FVB_PIX_FIRST       12'h000
`define FVB_LINE_FIRST      12'h001

`define FVB_RESP_OKAY       2'b00
`define FVB_RESP_SLVERR     2'b10

`endif

//--- logic/fvb_pkg.sv
// Types shared by the field 1 blanking block
package fvb_pkg;
    typedef logic [11:0] fvb_coord_t;

    typedef enum logic [1:0] {
        FVB_MODE_RAW   = 2'b00,
        FVB_MODE_BT656 = 2'b01,
        FVB_MODE_YC    = 2'b10,
        FVB_MODE_RSVD  = 2'b11
    } fvb_mode_e;
endpackage : fvb_pkg

//--- logic/fvb_if.sv
// Settings and timing state passed between register file and blanking timer
`timescale 1ns/10ps
interface fvb_if;
    import fvb_pkg::*;
    fvb_coord_t start_line;
    fvb_coord_t start_pixel;
    fvb_coord_t stop_line;
    fvb_coord_t stop_pixel;
    fvb_coord_t frame_width;
    fvb_coord_t frame_height;
    logic       run;
    fvb_coord_t line_count;
    fvb_coord_t pixel_count;
    logic       blank;

    modport cfg (output start_line, start_pixel, stop_line, stop_pixel, frame_width, frame_height, run,
                 input line_count, pixel_count, blank);
    modport tim (input start_line, start_pixel, stop_line, stop_pixel, frame_width, frame_height, run,
                 output line_count, pixel_count, blank);
endinterface : fvb_if

//--- logic/fvb_timer.sv
// Frame counters and field 1 vertical blanking level
`timescale 1ns/10ps
`include "fvb_defines.svh"
module fvb_timer
    import fvb_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    fvb_if.tim        tif
);
    fvb_coord_t pix_r;
    fvb_coord_t pix_nxt;
    fvb_coord_t line_r;
    fvb_coord_t line_nxt;
    logic       blank_r;
    logic       blank_nxt;
    logic       start_hit;
    logic       stop_hit;

    always_comb begin
        pix_nxt   = pix_r;
        line_nxt  = line_r;
        start_hit = (line_r == tif.start_line) && (pix_r == tif.start_pixel);
        stop_hit  = (line_r == tif.stop_line) && (pix_r == tif.stop_pixel);
        blank_nxt = blank_r;
        if (!tif.run) begin
            pix_nxt  = `FVB_PIX_FIRST;
            line_nxt = `FVB_LINE_FIRST;
        end else begin
            // Compare with >= so a width shrunk below the count still wraps
            if (pix_r >= tif.frame_width - 12'h001 || tif.frame_width == 12'h000) begin
                pix_nxt = `FVB_PIX_FIRST;
                if (line_r >= tif.frame_height) begin
                    line_nxt = `FVB_LINE_FIRST;
                end else begin
                    line_nxt = line_r + 12'h001;
                end
            end else begin
                pix_nxt = pix_r + 12'h001;
            end
            // Same match logic in every output mode, no code insertion involved
            if (start_hit) begin
                blank_nxt = 1'b1;
            end else if (stop_hit) begin
                blank_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pix_r   <= `FVB_PIX_FIRST;
            line_r  <= `FVB_LINE_FIRST;
            blank_r <= 1'b0;
        end else begin
            pix_r   <= pix_nxt;
            line_r  <= line_nxt;
            blank_r <= blank_nxt;
        end
    end

    assign tif.pixel_count = pix_r;
    assign tif.line_count  = line_r;
    assign tif.blank       = blank_r;
endmodule : fvb_timer

//--- logic/fvb_top.sv
// Field 1 vertical blanking generator with AXI4-Lite register access
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "fvb_defines.svh"

module fvb_top
    import fvb_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`FVB_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`FVB_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        vertical_blank_out,
    output logic                        f1_vbit_out,
    output fvb_mode_e                   output_mode
);
    fvb_if tif ();

    logic [31:0]            start_r;
    logic [31:0]            start_nxt;
    logic [31:0]            end_r;
    logic [31:0]            end_nxt;
    logic [31:0]            frame_r;
    logic [31:0]            frame_nxt;
    logic [31:0]            ctrl_r;
    logic [31:0]            ctrl_nxt;
    logic                   aw_held_r;
    logic                   aw_held_nxt;
    logic                   w_held_r;
    logic                   w_held_nxt;
    logic [`FVB_ADDR_W-1:0] awaddr_r;
    logic [`FVB_ADDR_W-1:0] awaddr_nxt;
    logic [31:0]            wdata_r;
    logic [31:0]            wdata_nxt;
    logic [3:0]             wstrb_r;
    logic [3:0]             wstrb_nxt;
    logic                   bvalid_r;
    logic                   bvalid_nxt;
    logic [1:0]             bresp_r;
    logic [1:0]             bresp_nxt;
    logic                   rvalid_r;
    logic                   rvalid_nxt;
    logic [1:0]             rresp_r;
    logic [1:0]             rresp_nxt;
    logic [31:0]            rdata_r;
    logic [31:0]            rdata_nxt;
    logic [31:0]            wmask;
    logic [31:0]            merged;
    logic [31:0]            stat_word;

    fvb_timer u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tif     (tif.tim)
    );

    assign tif.start_line   = start_r[`FVB_LINE_HI:`FVB_LINE_LO];
    assign tif.start_pixel  = start_r[`FVB_PIX_HI:`FVB_PIX_LO];
    assign tif.stop_line    = end_r[`FVB_LINE_HI:`FVB_LINE_LO];
    assign tif.stop_pixel   = end_r[`FVB_PIX_HI:`FVB_PIX_LO];
    assign tif.frame_height = frame_r[`FVB_LINE_HI:`FVB_LINE_LO];
    assign tif.frame_width  = frame_r[`FVB_PIX_HI:`FVB_PIX_LO];
    assign tif.run          = ctrl_r[`FVB_CTRL_RUN];

    // Ready outputs are combinational, valid outputs come straight from registers; one write and one read outstanding
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    assign vertical_blank_out = tif.blank;
    // Embedded V bit comes only from its control bit, never from the blanking matches
    assign f1_vbit_out = ctrl_r[`FVB_CTRL_VBIT];
    assign output_mode = fvb_mode_e'(ctrl_r[`FVB_CTRL_MODE_HI:`FVB_CTRL_MODE_LO]);

    assign stat_word = {tif.blank, 3'h0, tif.line_count, 4'h0, tif.pixel_count};

    always_comb begin
        wmask  = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
        merged = 32'h0000_0000;
        start_nxt   = start_r;
        end_nxt     = end_r;
        frame_nxt   = frame_r;
        ctrl_nxt    = ctrl_r;
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;

        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end
        if (aw_held_r && w_held_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = `FVB_RESP_OKAY;
            unique case (awaddr_r)
                `FVB_OFF_START: begin
                    merged    = (start_r & ~wmask) | (wdata_r & wmask);
                    start_nxt = merged & `FVB_COORD_MASK;
                end
                `FVB_OFF_END: begin
                    merged  = (end_r & ~wmask) | (wdata_r & wmask);
                    end_nxt = merged & `FVB_COORD_MASK;
                end
                `FVB_OFF_FRAME: begin
                    merged    = (frame_r & ~wmask) | (wdata_r & wmask);
                    frame_nxt = merged & `FVB_COORD_MASK;
                end
                `FVB_OFF_CTRL: begin
                    merged   = (ctrl_r & ~wmask) | (wdata_r & wmask);
                    ctrl_nxt = merged & `FVB_CTRL_MASK;
                end
                `FVB_OFF_STAT: begin
                    merged = 32'h0000_0000;
                end
                default: begin
                    bresp_nxt = `FVB_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end

        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `FVB_RESP_OKAY;
            unique case (s_axi_araddr)
                `FVB_OFF_START: rdata_nxt = start_r;
                `FVB_OFF_END:   rdata_nxt = end_r;
                `FVB_OFF_FRAME: rdata_nxt = frame_r;
                `FVB_OFF_CTRL:  rdata_nxt = ctrl_r;
                `FVB_OFF_STAT:  rdata_nxt = stat_word;
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = `FVB_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_r   <= `FVB_RST_REG;
            end_r     <= `FVB_RST_REG;
            frame_r   <= `FVB_RST_REG;
            ctrl_r    <= `FVB_RST_REG;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 6'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `FVB_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rresp_r   <= `FVB_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else begin
            start_r   <= start_nxt;
            end_r     <= end_nxt;
            frame_r   <= frame_nxt;
            ctrl_r    <= ctrl_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
        end
    end
endmodule : fvb_top

//--- test/fvb_chk.sv
// Bus and output checks for the field 1 blanking block
`timescale 1ns/10ps
`include "fvb_defines.svh"
module fvb_chk
    import fvb_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        f1_vbit_out,
    input wire fvb_mode_e   output_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_stands; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_stands: assert property (p_b_stands) else $error("write answer dropped early");
    property p_r_stands; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_stands: assert property (p_r_stands) else $error("read answer dropped early");
    property p_wr_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wr_block: assert property (p_wr_block) else $error("write taken while answer pending");
    property p_rd_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rd_block: assert property (p_rd_block) else $error("read taken while answer pending");
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    // Both channels taken together: held flags set on that edge, answer one edge later
    property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_err_zero; s_axi_rvalid && s_axi_rresp == `FVB_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
    property p_vbit_src; $changed({f1_vbit_out, output_mode}) |-> $rose(s_axi_bvalid); endproperty
    a_vbit_src: assert property (p_vbit_src) else $error("v bit or mode moved without a write");
endmodule : fvb_chk

bind fvb_top fvb_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .f1_vbit_out(f1_vbit_out), .output_mode(output_mode));

//--- test/fvb_sink.sv
// Display-side receiver that counts field 1 blanking periods
`timescale 1ns/10ps
module fvb_sink (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   vertical_blank_out,
    output logic [15:0] blank_starts
);
    logic blank_q_r;
    always_ff @(posedge aclk) begin
        blank_q_r <= aresetn ? vertical_blank_out : 1'b0;
        if (!aresetn) blank_starts <= 16'h0000;
        else if (vertical_blank_out && !blank_q_r) blank_starts <= blank_starts + 16'h0001;
    end
endmodule : fvb_sink

//--- test/test_fvb_top.sv
// Random and corner tests of the field 1 blanking block
`timescale 1ns/10ps
`include "fvb_defines.svh"
module test_fvb_top;
    import fvb_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, vbit, blank, v;
    logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    fvb_mode_e   mode;
    logic [15:0] starts;
    logic [11:0] fw = 12'h0, fh = 12'h0, sl = 12'h0, sp = 12'h0, el = 12'h0, ep = 12'h0, rp = 12'h0, rl = 12'h1;
    logic        rb = 1'b0, rrun = 1'b0, pend = 1'b0, pval = 1'b0;
    int          bad_count = 0, n_checks = 0, rises = 0;
    integer      seed = 32'ha9ebb8f8;
    always #2 aclk = ~aclk;
    fvb_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .vertical_blank_out(blank),
        .f1_vbit_out(vbit), .output_mode(mode));
    fvb_sink u_sink (.aclk(aclk), .aresetn(aresetn), .vertical_blank_out(blank), .blank_starts(starts));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    // No cycle limit of its own: only the watchdog ends a hung wait
    task automatic wr(input logic [5:0] a, input logic [31:0] dv, output logic [1:0] resp);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a; wdata <= dv; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin awvalid <= 1'b0; aw_done = 1'b1; end
            if (wvalid && wready) begin wvalid <= 1'b0; w_done = 1'b1; end
        end while (!(aw_done && w_done));
        do begin @(posedge aclk); end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [31:0] dv, output logic [1:0] resp);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        dv = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    // Reference timing: run takes hold one edge after the control write is taken
    always @(posedge aclk) begin
        if (aresetn) chk({31'h0, blank}, {31'h0, rb});
        pend <= awvalid && awready && awaddr == `FVB_OFF_CTRL;
        pval <= wdata[0];
        if (!aresetn) begin rb <= 1'b0; rrun <= 1'b0; rp <= 12'h0; rl <= 12'h1; end
        else begin
            if (pend) rrun <= pval;
            if (!rrun) begin rp <= 12'h0; rl <= 12'h1; end
            else begin
                if (rl == sl && rp == sp) begin rb <= 1'b1; rises += int'(!rb); end
                else if (rl == el && rp == ep) rb <= 1'b0;
                rp <= (rp + 12'h1 >= fw) ? 12'h0 : rp + 12'h1;
                if (rp + 12'h1 >= fw) rl <= (rl >= fh) ? 12'h1 : rl + 12'h1;
            end
        end
    end
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int a = 0; a < 16; a += 4) begin rd(6'(a), d, r); chk(d, 32'h0); end
        rd(`FVB_OFF_STAT, d, r); chk(d, 32'h0001_0000);
        wr(6'h14, $random(seed), r); chk({30'h0, r}, {30'h0, `FVB_RESP_SLVERR});
        rd(6'h14, d, r); chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, `FVB_RESP_SLVERR});
        for (int i = 0; i < 4; i++) begin
            fw = 12'(3 + $unsigned($random(seed)) % 6);
            fh = 12'(2 + $unsigned($random(seed)) % 3);
            sp = 12'($unsigned($random(seed)) % fw);
            sl = 12'(1 + $unsigned($random(seed)) % fh);
            ep = 12'($unsigned($random(seed)) % fw);
            el = 12'(1 + $unsigned($random(seed)) % fh);
            if (i == 1) begin el = sl; ep = sp; end
            v = 1'($random(seed));
            wr(`FVB_OFF_FRAME, {4'h0, fh, 4'h0, fw}, r);
            chk({30'h0, r}, {30'h0, `FVB_RESP_OKAY});
            wr(`FVB_OFF_START, {4'hf, sl, 4'hf, sp}, r);
            wr(`FVB_OFF_END, {4'ha, el, 4'h5, ep}, r);
            rd(`FVB_OFF_START, d, r); chk(d, {4'h0, sl, 4'h0, sp});
            chk({30'h0, r}, {30'h0, `FVB_RESP_OKAY});
            rd(`FVB_OFF_END, d, r); chk(d, {4'h0, el, 4'h0, ep});
            wr(`FVB_OFF_CTRL, {26'h0, 2'(i), 2'b00, v, 1'b1}, r);
            chk({31'h0, vbit}, {31'h0, v});
            chk({30'h0, mode}, {30'h0, 2'(i)});
            repeat (3 * fw * fh + 2) @(posedge aclk);
            wr(`FVB_OFF_CTRL, 32'h0, r);
        end
        chk({16'h0, starts}, 32'(rises));
        print_verdict();
    end
endmodule : test_fvb_top
